// ### design/uir_pkg.sv
// Package with register map, field positions and shared types for the serial infrared data path.
package uir_pkg;
	localparam int unsigned CLK_HZ            = 100_000_000;
	localparam logic [11:0] ADDR_BAUD_HIGH    = 12'h000;
	localparam logic [11:0] ADDR_BAUD_LOW     = 12'h004;
	localparam logic [11:0] ADDR_CTRL_ONE     = 12'h008;
	localparam logic [11:0] ADDR_STATUS_TWO   = 12'h014;
	localparam logic [11:0] ADDR_DATA_HIGH    = 12'h018;
	localparam logic [11:0] ADDR_DATA_LOW     = 12'h01c;
	localparam logic [11:0] ADDR_IR_CTRL      = 12'h020;
	localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h024;
	localparam logic [11:0] ADDR_IRQ_MASK     = 12'h028;
	localparam int          ST2_MAP_BIT       = 7;
	localparam int          ST2_TXINV_BIT     = 4;
	localparam int          ST2_RXINV_BIT     = 3;
	localparam int          ST2_LBRK_BIT      = 2;
	localparam int          ST2_SWDIR_BIT     = 1;
	localparam int          ST2_RXACT_BIT     = 0;
	localparam logic [7:0]  ST2_WRITE_MASK    = 8'h9e;
	localparam int          DH_RX9_BIT        = 7;
	localparam int          DH_TX9_BIT        = 6;
	localparam int          CR1_LOOP_BIT      = 7;
	localparam int          CR1_SWIRE_BIT     = 5;
	localparam int          CR1_NINE_BIT      = 4;
	localparam int          CR1_TXEN_BIT      = 3;
	localparam int          CR1_RXEN_BIT      = 2;
	localparam int          CR1_BRK_BIT       = 1;
	localparam int          IRC_EN_BIT        = 2;
	localparam int          IRQ_RX_BIT        = 0;
	localparam int          IRQ_TX_BIT        = 1;
	localparam int          IRQ_IDLE_BIT      = 2;
	localparam int          IRQ_FERR_BIT      = 3;
	localparam int          IRQ_W             = 4;
	localparam logic [3:0]  OVS               = 4'hf;
	localparam logic [3:0]  RX_FIRST_SLOT     = 4'h1;
	localparam logic [3:0]  RX_MID_SLOT       = 4'h8;
	localparam logic [3:0]  TX_LOAD_SLOT      = 4'h9;
	localparam logic [3:0]  FRAME_BITS_8      = 4'ha;
	localparam logic [3:0]  FRAME_BITS_9      = 4'hb;
	localparam logic [3:0]  BREAK_EXTRA       = 4'h3;
	localparam logic [4:0]  IR_HALF_BIT       = 5'h10;
	localparam int          IR_MIN_BPS        = 2400;
	localparam int          IR_MAX_BPS        = 115200;
	localparam logic [12:0] BAUD_RESET_DIV    = 13'h0004;
	typedef enum logic [1:0] {
		UIR_PW_3_16 = 2'h0,
		UIR_PW_1_16 = 2'h1,
		UIR_PW_1_32 = 2'h2,
		UIR_PW_1_4  = 2'h3
	} uir_pw_e;
	typedef enum logic [1:0] {
		UIR_TX_IDLE  = 2'h0,
		UIR_TX_SHIFT = 2'h1,
		UIR_TX_BREAK = 2'h3
	} uir_tx_e;
	typedef struct packed {
		logic       valid;
		logic       ninth;
		logic [7:0] data;
	} uir_word_s;
endpackage

// ### design/uir_data_path.sv
// Serial data path with status register two, data registers and infrared encoder and decoder.
`timescale 1ns/100ps
// Operation
// - Offsets zero to two show baud and control, or alternate set when map bit set.
// - Transmit invert bit flips sent line levels.
// - Receive invert bit flips received levels in both line formats.
// - Long break select stretches sent breaks to 13 or 14 bits only.
// - In single-wire mode the direction bit makes the transmit pin drive or listen.
// - Receiver active flag sets on zero in first sample slot, clears on idle.
// - Data registers read receive buffer, writes load transmit buffer, ninth received bit read only.
// - Received ninth bit lands in high register bit 7, rest in low register.
// - High register bit 6 is sent as ninth bit until software rewrites it.
// - Transmitter and receiver run independently from one shared baud generator.
// - Infrared coding is meant for rates from 2.4 to 115.2 kbit/s.
// - Each zero bit of a data frame gives one centred pulse of selectable width; ones and break bits give none.
// - Encoder pulses high on low idle, or low on high idle when inverted.
// - Decoder stretches pulses into zeros, expecting polarity set by receive invert.
// - Core gives 16x and 32x clocks; transmit uses both, decoder only 16x.
// - Frames hold start, eight or nine data bits and stop: 10 or 11 bits.
// - A 13-bit modulus counter makes the 16x clock; divided by sixteen it paces transmit.
module uir_data_path
	import uir_pkg::*;
#(
	parameter int unsigned IDLE_BITS = 10
) (
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        rxd_i,
	input  wire logic        txd_pin_i,
	output logic             txd_o,
	output logic             txd_oe_b_o,
	output logic             irq_o
);
	logic [12:0] baud_div;
	logic [7:0]  ctrl_one;
	logic [7:0]  alt_ctrl_one;
	logic [7:0]  alt_ctrl_two;
	logic [7:0]  status_two;
	logic        tx_ninth_bit;
	logic [7:0]  tx_buf;
	logic        tx_buf_full;
	uir_word_s   rx_word;
	logic [2:0]  ir_ctrl;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	logic [12:0] baud_cnt;
	logic        tick16;
	logic        tick32;
	logic        tx_line;
	logic [3:0]  idle_need;
	logic [2:0]  rx_sync;
	logic        rx_line;
	logic        rx_bit;
	logic [3:0]  ir_stretch;
	logic        rx_busy;
	logic [3:0]  rx_slot;
	logic [3:0]  rx_idx;
	logic [9:0]  rx_shift;
	logic [3:0]  idle_cnt;
	logic        idle_seen;
	logic [3:0]  tx_slot;
	logic [4:0]  tx_sub;
	logic [3:0]  tx_idx;
	logic [3:0]  tx_len;
	logic [10:0] tx_shift;
	logic        tx_bit;
	uir_tx_e     tx_state;
	logic [2:0]  tsync;
	logic        apb_wr;
	logic        apb_rd;
	logic        nine;
	logic        tx_inv;
	logic        rx_inv;
	logic        ir_en;
	logic        ir_pulse;
	logic        rx_done;
	logic        tx_load;
	logic        rx_ferr;
	logic [7:0]  next_byte;
	assign apb_wr   = psel_i && penable_i && pwrite_i;
	assign apb_rd   = psel_i && penable_i && !pwrite_i;
	assign nine     = ctrl_one[CR1_NINE_BIT];
	assign tx_inv   = status_two[ST2_TXINV_BIT];
	assign rx_inv   = status_two[ST2_RXINV_BIT];
	assign ir_en    = ir_ctrl[IRC_EN_BIT];
	assign next_byte = pwdata_i[7:0];
	assign idle_need = 4'(IDLE_BITS) + {3'h0, nine};

	function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
		return (a == reg_addr);
	endfunction

	function automatic logic [4:0] pulse_half(input logic [1:0] pw);
		case (pw)
			UIR_PW_1_32: pulse_half = 5'h00;
			UIR_PW_1_16: pulse_half = 5'h01;
			UIR_PW_3_16: pulse_half = 5'h03;
			UIR_PW_1_4:  pulse_half = 5'h04;
			default:     pulse_half = 5'h03;
		endcase
	endfunction

	// Register writes, byte lane zero carries the eight-bit registers.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			baud_div     <= BAUD_RESET_DIV;
			ctrl_one     <= 8'h00;
			alt_ctrl_one <= 8'h00;
			alt_ctrl_two <= 8'h00;
			status_two[7:1] <= 7'h00;
			tx_ninth_bit <= 1'b0;
			ir_ctrl      <= 3'h0;
			irq_mask     <= '0;
		end else if (apb_wr && pstrb_i[0]) begin
			if (status_two[ST2_MAP_BIT]) begin
				if (hit(paddr_i, ADDR_BAUD_LOW)) alt_ctrl_one <= next_byte;
				if (hit(paddr_i, ADDR_CTRL_ONE)) alt_ctrl_two <= next_byte;
			end else begin
				if (hit(paddr_i, ADDR_BAUD_HIGH)) baud_div[12:8] <= next_byte[4:0];
				if (hit(paddr_i, ADDR_BAUD_LOW)) baud_div[7:0] <= next_byte;
				if (hit(paddr_i, ADDR_CTRL_ONE)) ctrl_one <= next_byte;
			end
			if (hit(paddr_i, ADDR_STATUS_TWO)) status_two[7:1] <= next_byte[7:1] & ST2_WRITE_MASK[7:1];
			if (hit(paddr_i, ADDR_DATA_HIGH)) tx_ninth_bit <= next_byte[DH_TX9_BIT];
			if (hit(paddr_i, ADDR_IR_CTRL)) ir_ctrl <= next_byte[2:0];
			if (hit(paddr_i, ADDR_IRQ_MASK)) irq_mask <= next_byte[IRQ_W-1:0];
		end
	end

	// Receiver active flag lives in bit zero of status two.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			status_two[ST2_RXACT_BIT] <= 1'b0;
		end else if (tick16 && !rx_busy && rx_bit == 1'b0 && ctrl_one[CR1_RXEN_BIT]) begin
			status_two[ST2_RXACT_BIT] <= 1'b1;
		end else if (idle_seen) begin
			status_two[ST2_RXACT_BIT] <= 1'b0;
		end
	end

	// Shared baud generator: 16x tick, and a 32x tick at its half period.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			baud_cnt <= 13'h0001;
			tick16   <= 1'b0;
			tick32   <= 1'b0;
		end else if (baud_div == 13'h0000) begin
			tick16 <= 1'b0;
			tick32 <= 1'b0;
		end else begin
			tick16 <= (baud_cnt >= baud_div);
			tick32 <= (baud_cnt >= baud_div) || (baud_cnt == {1'b0, baud_div[12:1]});
			baud_cnt <= (baud_cnt >= baud_div) ? 13'h0001 : baud_cnt + 13'h0001;
		end
	end

	// Receive pin synchroniser; a change counts once stages two and three agree.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			rx_sync <= 3'h7;
			tsync   <= 3'h7;
			rx_line <= 1'b1;
			tx_line <= 1'b1;
		end else begin
			rx_sync <= {rx_sync[1:0], rxd_i};
			tsync   <= {tsync[1:0], txd_pin_i};
			if (rx_sync[2] == rx_sync[1]) rx_line <= rx_sync[2];
			if (tsync[2] == tsync[1]) tx_line <= tsync[2];
		end
	end

	// Decoder stretches a pulse to a full bit of 16x ticks.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			ir_stretch <= 4'h0;
		end else if ((rx_line ^ rx_inv) && ir_en) begin
			ir_stretch <= OVS;
		end else if (tick16 && ir_stretch != 4'h0) begin
			ir_stretch <= ir_stretch - 4'h1;
		end
	end

	always_comb begin
		if (ctrl_one[CR1_LOOP_BIT]) rx_bit = tx_bit;
		else if (ctrl_one[CR1_SWIRE_BIT] && !status_two[ST2_SWDIR_BIT]) rx_bit = (tx_line ^ rx_inv);
		else if (ir_en) rx_bit = !((rx_line ^ rx_inv) || ir_stretch != 4'h0);
		else rx_bit = rx_line ^ rx_inv;
	end

	// Receiver: start search, mid-bit sampling, ten or eleven bit frames.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			rx_busy   <= 1'b0;
			rx_slot   <= 4'h0;
			rx_idx    <= 4'h0;
			rx_shift  <= 10'h000;
			rx_done   <= 1'b0;
			rx_ferr   <= 1'b0;
			idle_cnt  <= 4'h0;
			idle_seen <= 1'b0;
		end else begin
			rx_done   <= 1'b0;
			rx_ferr   <= 1'b0;
			idle_seen <= 1'b0;
			if (tick16 && ctrl_one[CR1_RXEN_BIT]) begin
				if (!rx_busy) begin
					if (!rx_bit) begin
						rx_busy  <= 1'b1;
						rx_slot  <= RX_FIRST_SLOT;
						rx_idx   <= 4'h0;
						idle_cnt <= 4'h0;
					end else begin
						rx_slot <= rx_slot + 4'h1;
						if (rx_slot == OVS) begin
							idle_cnt <= (idle_cnt == OVS) ? idle_cnt : idle_cnt + 4'h1;
							if (idle_cnt == idle_need - 4'h1) idle_seen <= 1'b1;
						end
					end
				end else begin
					rx_slot <= rx_slot + 4'h1;
					if (rx_slot == RX_MID_SLOT - 4'h1) begin
						if (rx_idx == 4'h0 && rx_bit) begin
							rx_busy <= 1'b0;
						end else if (rx_idx == (nine ? FRAME_BITS_9 : FRAME_BITS_8) - 4'h1) begin
							rx_busy <= 1'b0;
							rx_done <= 1'b1;
							rx_ferr <= !rx_bit;
						end else begin
							rx_shift <= {rx_bit, rx_shift[9:1]};
						end
						rx_idx <= rx_idx + 4'h1;
					end
				end
			end
		end
	end

	// Receive buffer holds the last frame with its ninth bit.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			rx_word <= '0;
		end else if (rx_done) begin
			rx_word.valid <= 1'b1;
			rx_word.ninth <= nine ? rx_shift[9] : 1'b0;
			rx_word.data  <= nine ? rx_shift[8:1] : rx_shift[9:2];
		end else if (apb_rd && hit(paddr_i, ADDR_DATA_LOW)) begin
			rx_word.valid <= 1'b0;
		end
	end

	// Transmit buffer: low register write queues the frame.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			tx_buf      <= 8'h00;
			tx_buf_full <= 1'b0;
		end else if (apb_wr && pstrb_i[0] && hit(paddr_i, ADDR_DATA_LOW)) begin
			tx_buf      <= next_byte;
			tx_buf_full <= 1'b1;
		end else if (tx_load) begin
			tx_buf_full <= 1'b0;
		end
	end

	assign tx_load = (tx_state == UIR_TX_IDLE) && tx_buf_full && tick16 && ctrl_one[CR1_TXEN_BIT] && tx_slot == OVS;

	// Transmitter paced by 16x tick divided by sixteen.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			tx_state <= UIR_TX_IDLE;
			tx_slot  <= 4'h0;
			tx_idx   <= 4'h0;
			tx_len   <= FRAME_BITS_8;
			tx_shift <= 11'h7ff;
		end else if (tick16) begin
			tx_slot <= tx_slot + 4'h1;
			case (tx_state)
				UIR_TX_IDLE: begin
					if (tx_load) begin
						tx_state <= UIR_TX_SHIFT;
						tx_idx   <= 4'h0;
						tx_len   <= nine ? FRAME_BITS_9 : FRAME_BITS_8;
						tx_shift <= nine ? {1'b1, tx_ninth_bit, tx_buf, 1'b0} : {2'b11, tx_buf, 1'b0};
					end else if (tx_slot == OVS && ctrl_one[CR1_BRK_BIT] && ctrl_one[CR1_TXEN_BIT]) begin
						tx_state <= UIR_TX_BREAK;
						tx_idx   <= 4'h0;
						tx_len   <= (nine ? FRAME_BITS_9 : FRAME_BITS_8)
							+ (status_two[ST2_LBRK_BIT] ? BREAK_EXTRA : 4'h0);
						tx_shift <= 11'h000;
					end
				end
				UIR_TX_SHIFT, UIR_TX_BREAK: begin
					if (tx_slot == OVS) begin
						tx_shift <= {1'b1, tx_shift[10:1]};
						tx_idx   <= tx_idx + 4'h1;
						if (tx_idx == tx_len - 4'h1) tx_state <= UIR_TX_IDLE;
					end
				end
				default: tx_state <= UIR_TX_IDLE;
			endcase
		end
	end

	assign tx_bit = (tx_state == UIR_TX_IDLE) ? 1'b1 : (tx_state == UIR_TX_BREAK) ? 1'b0 : tx_shift[0];

	// Pulse position counter in 32x steps within each bit.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			tx_sub <= 5'h00;
		end else if (tick16 && tx_slot == OVS) begin
			tx_sub <= 5'h00;
		end else if (tick32) begin
			tx_sub <= tx_sub + 5'h01;
		end
	end

	always_comb begin
		ir_pulse = (tx_bit == 1'b0) && (tx_state == UIR_TX_SHIFT) && (tx_sub >= IR_HALF_BIT - pulse_half(ir_ctrl[1:0]))
			&& (tx_sub <= IR_HALF_BIT + pulse_half(ir_ctrl[1:0]) - ((ir_ctrl[1:0] == UIR_PW_1_32) ? 5'h00 : 5'h01));
	end

	// Pin drive: polarity, infrared coding and single-wire direction.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			txd_o      <= 1'b1;
			txd_oe_b_o <= 1'b0;
		end else begin
			if (ir_en) txd_o <= ir_pulse ^ tx_inv;
			else txd_o <= tx_bit ^ tx_inv;
			txd_oe_b_o <= ctrl_one[CR1_SWIRE_BIT] && !status_two[ST2_SWDIR_BIT];
		end
	end

	// Sticky interrupt status, cleared by writing one; a set wins over a clear.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			irq_stat <= '0;
			irq_o    <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~((apb_wr && pstrb_i[0] && hit(paddr_i, ADDR_IRQ_STATUS)) ? next_byte[IRQ_W-1:0] : '0))
				| {rx_ferr, idle_seen, tx_load, rx_done};
			irq_o    <= |(irq_stat & irq_mask);
		end
	end

	// APB answer, zero wait states; unmapped reads give zero with an error.
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			prdata_o  <= 32'h0000_0000;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= psel_i && !penable_i;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			if (psel_i && !penable_i) begin
				case (paddr_i)
					ADDR_BAUD_HIGH: prdata_o[7:0] <= status_two[ST2_MAP_BIT] ? {4'h0, irq_stat} : {3'h0, baud_div[12:8]};
					ADDR_BAUD_LOW:  prdata_o[7:0] <= status_two[ST2_MAP_BIT] ? alt_ctrl_one : baud_div[7:0];
					ADDR_CTRL_ONE:  prdata_o[7:0] <= status_two[ST2_MAP_BIT] ? alt_ctrl_two : ctrl_one;
					ADDR_STATUS_TWO: prdata_o[7:0] <= status_two;
					ADDR_DATA_HIGH: prdata_o[7:0] <= {rx_word.ninth, tx_ninth_bit, 6'h00};
					ADDR_DATA_LOW:  prdata_o[7:0] <= rx_word.data;
					ADDR_IR_CTRL:   prdata_o[7:0] <= {5'h00, ir_ctrl};
					ADDR_IRQ_STATUS: prdata_o[7:0] <= {4'h0, irq_stat};
					ADDR_IRQ_MASK:  prdata_o[7:0] <= {4'h0, irq_mask};
					default:        pslverr_o <= 1'b1;
				endcase
			end
		end
	end
endmodule // uir_data_path

// ### sim/uir_data_path_assertions.sv
// Checker with port-level assertions for the serial infrared data path.
`timescale 1ns/100ps
module uir_data_path_assertions
	import uir_pkg::*;
(
	input wire logic        core_clk_i,
	input wire logic        rst_b_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0]  pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        rxd_i,
	input wire logic        txd_pin_i,
	input wire logic        txd_o,
	input wire logic        txd_oe_b_o,
	input wire logic        irq_o
);
	logic       wr_go;
	logic       mapped;
	logic [7:0] st2_m;
	logic [7:0] ctl_m;
	logic [7:0] irc_m;
	logic [3:0] settle;
	logic [5:0] hi_cnt;
	assign wr_go = psel_i && penable_i && pwrite_i && pready_o && pstrb_i[0];
	assign mapped = paddr_i inside {12'h000, 12'h004, 12'h008, 12'h014, 12'h018, 12'h01c, 12'h020, 12'h024, 12'h028};
	function automatic logic [5:0] pw_clks(input logic [1:0] s);
		case (s)
			2'h0: return 6'd12;
			2'h1: return 6'd4;
			2'h2: return 6'd2;
			default: return 6'd16;
		endcase
	endfunction
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			st2_m <= 8'h00;
			ctl_m <= 8'h00;
			irc_m <= 8'h00;
		end else if (wr_go) begin
			if (paddr_i == ADDR_STATUS_TWO) st2_m <= pwdata_i[7:0];
			if (paddr_i == ADDR_CTRL_ONE && !st2_m[ST2_MAP_BIT]) ctl_m <= pwdata_i[7:0];
			if (paddr_i == ADDR_IR_CTRL) irc_m <= pwdata_i[7:0];
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i || wr_go) settle <= 4'h0;
		else if (settle != 4'hf) settle <= settle + 4'h1;
	end
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i || !txd_o) hi_cnt <= 6'd0;
		else if (hi_cnt != 6'd63) hi_cnt <= hi_cnt + 6'd1;
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_ready_answer;
		psel_i && !penable_i |=> pready_o;
	endproperty
	a_ready_answer: assert property (p_ready_answer) else $error("no ready after setup");
	property p_ready_pulse;
		pready_o |-> penable_i ##1 !pready_o;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready not a single pulse");
	property p_unmapped;
		psel_i && !penable_i && !mapped |=> pslverr_o && prdata_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_mapped;
		psel_i && !penable_i && mapped |=> !pslverr_o;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped access refused");
	property p_reset_out;
		$rose(rst_b_i) |-> txd_o && !txd_oe_b_o && !irq_o && !pready_o;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs wrong after reset");
	property p_pin_dir;
		settle >= 4'h6 |-> txd_oe_b_o == (ctl_m[CR1_SWIRE_BIT] && !st2_m[ST2_SWDIR_BIT]);
	endproperty
	a_pin_dir: assert property (p_pin_dir) else $error("pin direction wrong");
	property p_idle_level;
		settle >= 4'h6 && !ctl_m[CR1_TXEN_BIT] && !ctl_m[CR1_BRK_BIT]
			|-> txd_o == (irc_m[IRC_EN_BIT] ~^ st2_m[ST2_TXINV_BIT]);
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("idle level wrong");
	property p_ir_width;
		$fell(txd_o) && irc_m[IRC_EN_BIT] && !st2_m[ST2_TXINV_BIT] && settle >= 4'h6 && hi_cnt < 6'd32
			|-> hi_cnt == pw_clks(irc_m[1:0]);
	endproperty
	a_ir_width: assert property (p_ir_width) else $error("infrared pulse width wrong");
	property p_ir_short;
		irc_m[IRC_EN_BIT] && !st2_m[ST2_TXINV_BIT] && settle >= 4'h6 |-> hi_cnt <= 6'd16;
	endproperty
	a_ir_short: assert property (p_ir_short) else $error("infrared line high too long");
endmodule // uir_data_path_assertions

bind uir_data_path uir_data_path_assertions chk_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rxd_i(rxd_i), .txd_pin_i(txd_pin_i),
	.txd_o(txd_o), .txd_oe_b_o(txd_oe_b_o), .irq_o(irq_o));

// ### sim/uir_remote_peer.sv
// Remote serial peer that sends frames on the receive line and captures frames from the transmit line.
`timescale 1ns/100ps
module uir_remote_peer #(
	parameter int BIT_CLKS = 64
) (
	input  wire logic core_clk_i,
	input  wire logic txd_i,
	input  wire logic listen_i,
	input  wire logic inv_i,
	input  wire logic ir_i,
	input  wire logic nine_i,
	output logic      rxd_o
);
	logic [8:0] got;
	logic       got_stop;
	logic       busy;
	int         n_got;
	int         nb;
	initial begin
		rxd_o = 1'b1;
		busy = 1'b0;
		n_got = 0;
	end
	always @(posedge core_clk_i) begin
		if (!busy) rxd_o <= inv_i ^ !ir_i;
	end
	// Sends start, data first bit lowest, stop; an infrared zero is a centred pulse.
	task automatic send(input logic [8:0] d);
		logic [10:0] f;
		f = nine_i ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
		busy = 1'b1;
		for (int i = 0; i < 11; i++) begin
			for (int c = 0; c < BIT_CLKS; c++) begin
				@(posedge core_clk_i);
				rxd_o <= inv_i ^ (ir_i ? (!f[i] && c >= 28 && c < 40) : f[i]);
			end
		end
		busy <= 1'b0;
	endtask
	// Samples each bit in its middle after a start edge.
	always begin
		@(posedge core_clk_i);
		if (listen_i && (txd_i ^ inv_i) == 1'b0) begin
			nb = nine_i ? 9 : 8;
			got = 9'h0;
			repeat (BIT_CLKS / 2) @(posedge core_clk_i);
			for (int i = 0; i <= nb; i++) begin
				repeat (BIT_CLKS) @(posedge core_clk_i);
				if (i < nb) got[i] = txd_i ^ inv_i;
				else got_stop = txd_i ^ inv_i;
			end
			n_got++;
		end
	end
endmodule // uir_remote_peer

// ### sim/uir_data_path_tb.sv
// Self-checking testbench for the serial infrared data path.
`timescale 1ns/100ps
module uir_data_path_tb
	import uir_pkg::*;
;
	typedef struct packed {
		logic        w;
		logic [11:0] a;
		logic [7:0]  d;
		logic [7:0]  e;
		logic        err;
	} uir_row_s;
	logic core_clk, rst_b, psel, penable, pwrite, rxd, txd, oe_b, irq, pready, pslverr, rerr;
	logic listen, inv, ir, nine, txd_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat, cnt, n, rises;
	int err_total, num_checks, n0;
	wire txd_pin = oe_b ? 1'b1 : txd;
	uir_row_s rows [12] = '{'{0, 12'h014, 8'h00, 8'h00, 0}, '{0, 12'h004, 8'h00, 8'h04, 0},
		'{0, 12'h000, 8'h00, 8'h00, 0}, '{1, 12'h014, 8'hf7, 8'h00, 0}, '{0, 12'h014, 8'h00, 8'h96, 0},
		'{1, 12'h014, 8'h00, 8'h00, 0}, '{1, 12'h028, 8'h0f, 8'h00, 0}, '{0, 12'h028, 8'h00, 8'h0f, 0},
		'{1, 12'h028, 8'h00, 8'h00, 0}, '{0, 12'h024, 8'h00, 8'h00, 0}, '{0, 12'h030, 8'h00, 8'h00, 1},
		'{1, 12'h030, 8'h55, 8'h00, 1}};
	uir_data_path dut_u (.core_clk_i(core_clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .rxd_i(rxd), .txd_pin_i(txd_pin), .txd_o(txd),
		.txd_oe_b_o(oe_b), .irq_o(irq));
	uir_remote_peer peer_u (.core_clk_i(core_clk), .txd_i(txd_pin), .listen_i(listen), .inv_i(inv), .ir_i(ir),
		.nine_i(nine), .rxd_o(rxd));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		txd_q <= txd;
		if (txd === 1'b1 && txd_q === 1'b0) rises <= rises + 1;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check({31'h0, pready}, 32'h1);
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 8'h00);
	endtask
	task automatic clks(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	initial begin
		{rst_b, psel, penable, pwrite, listen, inv, ir, nine, txd_q} = '0;
		{paddr, pwdata, rises} = '0;
		err_total = 0;
		num_checks = 0;
		clks(6);
		rst_b <= 1'b1;
		clks(1);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			check({31'h0, rerr}, {31'h0, rows[i].err});
			if (!rows[i].w) check(rdat, {24'h0, rows[i].e});
		end
		wr(ADDR_CTRL_ONE, 8'h0c);
		wr(ADDR_STATUS_TWO, 8'h80);
		wr(ADDR_CTRL_ONE, 8'h33);
		rd(ADDR_CTRL_ONE);
		check(rdat, 32'h33);
		wr(ADDR_STATUS_TWO, 8'h00);
		rd(ADDR_CTRL_ONE);
		check(rdat, 32'h0c);
		listen <= 1'b1;
		for (int m = 0; m < 2; m++) begin
			nine <= m[0];
			wr(ADDR_IRQ_MASK, m ? 8'h00 : 8'h01);
			wr(ADDR_CTRL_ONE, m ? 8'h1c : 8'h0c);
			wr(ADDR_DATA_HIGH, 8'hc0);
			n0 = peer_u.n_got;
			fork
				begin
					wr(ADDR_DATA_LOW, 8'ha5);
					clks(200);
					rd(ADDR_STATUS_TWO);
					check(rdat & 32'h1, 32'h1);
				end
				peer_u.send(9'h15a);
			join
			for (int k = 0; k < 3000 && peer_u.n_got == n0; k++) clks(1);
			check({23'h0, peer_u.got}, m ? 32'h1a5 : 32'h0a5);
			check({31'h0, peer_u.got_stop}, 32'h1);
			check({31'h0, irq}, m ? 32'h0 : 32'h1);
			rd(ADDR_DATA_HIGH);
			check(rdat & 32'h80, m ? 32'h80 : 32'h0);
			rd(ADDR_DATA_LOW);
			check(rdat, 32'h5a);
			wr(ADDR_IRQ_STATUS, 8'h0f);
			clks(2);
			check({31'h0, irq}, 32'h0);
			clks(1500);
			rd(ADDR_STATUS_TWO);
			check(rdat & 32'h1, 32'h0);
		end
		listen <= 1'b0;
		nine <= 1'b0;
		wr(ADDR_CTRL_ONE, 8'h0c);
		wr(ADDR_STATUS_TWO, 8'h18);
		inv <= 1'b1;
		clks(1000);
		rd(ADDR_DATA_LOW);
		listen <= 1'b1;
		n0 = peer_u.n_got;
		fork
			wr(ADDR_DATA_LOW, 8'h3c);
			peer_u.send(9'h0c3);
		join
		for (int k = 0; k < 3000 && peer_u.n_got == n0; k++) clks(1);
		check({23'h0, peer_u.got}, 32'h3c);
		clks(200);
		rd(ADDR_DATA_LOW);
		check(rdat, 32'hc3);
		listen <= 1'b0;
		inv <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_STATUS_TWO, k ? 8'h04 : 8'h00);
			wr(ADDR_CTRL_ONE, k == 2 ? 8'h1e : 8'h0e);
			for (n = 0; txd !== 1'b0 && n < 3000; n++) clks(1);
			for (cnt = 0; txd === 1'b0 && cnt < 2000; cnt++) clks(1);
			wr(ADDR_CTRL_ONE, 8'h0c);
			clks(1500);
			check(cnt, k == 0 ? 32'd640 : k == 1 ? 32'd832 : 32'd896);
		end
		wr(ADDR_STATUS_TWO, 8'h00);
		for (int k = 0; k < 3; k++) begin
			wr(ADDR_CTRL_ONE, k < 2 ? 8'h2c : 8'h0c);
			wr(ADDR_STATUS_TWO, k == 1 ? 8'h02 : 8'h00);
			clks(3);
			check({31'h0, oe_b}, k == 0 ? 32'h1 : 32'h0);
		end
		ir <= 1'b1;
		for (int w = 0; w < 4; w++) begin
			wr(ADDR_IR_CTRL, 8'h04 | 8'(w));
			clks(1000);
			rd(ADDR_DATA_LOW);
			rises <= '0;
			fork
				wr(ADDR_DATA_LOW, 8'h96);
				peer_u.send(9'h069);
			join
			clks(200);
			check(rises, 32'd5);
			rd(ADDR_DATA_LOW);
			check(rdat, 32'h69);
		end
		stop_test();
	end
	initial begin
		clks(60000);
		err_total++;
		stop_test();
	end
endmodule // uir_data_path_tb
